// >>> verification/sfwd_engine_tb_top.sv
`timescale 1ns/100ps
module sfwd_engine_tb_top
  import sfwd_pkg::*;
;
  localparam logic [5:0] LINE_DT = 6'h2A;
  logic          clk = 1'b0;
  logic          nrst = 1'b0;
  logic          reg_wr = 1'b0;
  logic          reg_rd = 1'b0;
  logic [7:0]    reg_addr = 8'h00;
  logic [7:0]    reg_wdata = 8'h00;
  logic [7:0]    reg_rdata;
  sfwd_head_type head_a = '0;
  sfwd_head_type head_b = '0;
  logic [1:0]    vc_a = 2'h0;
  logic [1:0]    vc_b = 2'h0;
  logic          slow = 1'b0;
  logic          pop_a, pop_b, tx_ready, synced, sync_lost, tx_enable;
  logic [2:0]    lane_cnt;
  sfwd_tx_type   tx;
  sfwd_head_type qa[$], qb[$];
  sfwd_tx_type   expq[$];
  int            err_count = 0;
  int            checks_done = 0;
  int            cyc = 0;

  sfwd_engine i_sfwd_engine (.sys_clk_i(clk), .nrst_i(nrst), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
    .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_rdata_o(reg_rdata), .head_a_i(head_a),
    .head_b_i(head_b), .vc_a_i(vc_a), .vc_b_i(vc_b), .pop_a_o(pop_a), .pop_b_o(pop_b),
    .tx_ready_i(tx_ready), .tx_o(tx), .synced_o(synced), .sync_lost_o(sync_lost),
    .tx_enable_o(tx_enable), .tx_lane_count_o(lane_cnt));
  sfwd_rx_model i_sfwd_rx_model (.sys_clk_i(clk), .nrst_i(nrst), .slow_i(slow), .tx_i(tx),
    .tx_ready_o(tx_ready));

  always #2 clk = ~clk;

  // Show-ahead buffers: head takes the queue front on every falling edge, so a pop shows half a cycle later
  always @(negedge clk) begin
    head_a <= qa.size() ? qa[0] : '0;
    head_b <= qb.size() ? qb[0] : '0;
  end
  always @(posedge clk) begin
    if (pop_a === 1'b1 && qa.size()) qa.delete(0);
    if (pop_b === 1'b1 && qb.size()) qb.delete(0);
  end

  // Hang guard, well above the few hundred cycles the tests need
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t %s got=%h exp=%h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk);
    reg_rd = 1'b0;
    chk("register read", reg_rdata, exp);
  endtask

  task automatic do_reset();
    @(negedge clk);
    nrst = 1'b0;
    qa.delete();
    qb.delete();
    expq.delete();
    repeat (4) @(negedge clk);
    nrst = 1'b1;
  endtask

  task automatic start(input logic [7:0] mode, input logic [1:0] va, input logic [1:0] vb, input logic s);
    do_reset();
    vc_a = va;
    vc_b = vb;
    slow = s;
    wr(SFWD_TX_CTL_OFS, 8'h01);
    wr(SFWD_MODE_OFS, mode);
    wr(SFWD_PORT_FWD_OFS, 8'h00);
  endtask

  // One packet into a buffer; n is 1 for frame start or end
  task automatic pkt(input bit b, input logic [1:0] k, input int n, input logic [7:0] base);
    sfwd_head_type h;
    for (int i = 0; i < n; i++) begin
      h = '0;
      h.valid = 1'b1;
      h.sop = (i == 0);
      h.eop = (i == n - 1);
      h.kind = k;
      h.dt = (k == SFWD_KIND_LINE) ? LINE_DT : 6'h00;
      h.wc = (k == SFWD_KIND_LINE) ? 16'(n) : 16'h0000;
      h.data = 8'(base + i);
      if (b) qb.push_back(h);
      else qa.push_back(h);
    end
  endtask

  // Aligned sources with identical geometry
  task automatic frame(input int lines);
    pkt(0, SFWD_KIND_FS, 1, 8'h00);
    pkt(1, SFWD_KIND_FS, 1, 8'h00);
    for (int l = 0; l < lines; l++) begin
      pkt(0, SFWD_KIND_LINE, 3, 8'(8'h10 * (l + 1)));
      pkt(1, SFWD_KIND_LINE, 3, 8'(8'h10 * (l + 1) + 8'h08));
    end
    pkt(0, SFWD_KIND_FE, 1, 8'h00);
    pkt(1, SFWD_KIND_FE, 1, 8'h00);
  endtask

  task automatic ex(input logic [1:0] k, input logic [1:0] vc, input int n, input logic [7:0] base,
                    input logic [15:0] wc, input bit s, input bit e, input logic [15:0] c);
    sfwd_tx_type t;
    for (int i = 0; i < n; i++) begin
      t = '0;
      t.valid = 1'b1;
      t.kind = k;
      t.vc = vc;
      t.sop = s && (i == 0);
      t.eop = e && (i == n - 1);
      t.dt = (k == SFWD_KIND_LINE) ? LINE_DT : 6'h00;
      t.wc = (k == SFWD_KIND_LINE) ? wc : 16'h0000;
      t.data = (k == SFWD_KIND_LINE) ? 8'(base + i) : 8'h00;
      t.crc = (i == n - 1) ? c : 16'h0000;
      expq.push_back(t);
    end
  endtask

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++) r = r[0] ? ((r >> 1) ^ SFWD_CRC_POLY) : (r >> 1);
    return r;
  endfunction

  // Waits for the expected beats, then a while longer so extra beats show up
  task automatic check_seq(input string name);
    sfwd_tx_type g;
    for (int w = 0; w < 3000 && i_sfwd_rx_model.beats.size() < expq.size(); w++) @(negedge clk);
    repeat (40) @(negedge clk);
    chk("beat count", i_sfwd_rx_model.beats.size(), expq.size());
    for (int i = 0; i < expq.size() && i < i_sfwd_rx_model.beats.size(); i++) begin
      g = i_sfwd_rx_model.beats[i];
      if (expq[i].kind != SFWD_KIND_LINE) {g.dt, g.wc, g.data} = '0;
      if (expq[i].crc === 16'h0000) g.crc = 16'h0000;
      chk("beat", g, expq[i]);
    end
    $display("Test %s finished", name);
  endtask

  initial begin
    logic [15:0] c;
    logic [7:0]  ba;
    // Reset values, refusal while disabled, register fields
    do_reset();
    chk("lanes", lane_cnt, SFWD_LANES_MAX);
    rchk(SFWD_PORT_FWD_OFS, SFWD_PORT_FWD_RST);
    rchk(SFWD_MODE_OFS, SFWD_MODE_RST);
    rchk(SFWD_TX_CTL_OFS, SFWD_TX_CTL_RST);
    rchk(8'h40, 8'h00);
    frame(0);
    repeat (20) @(negedge clk);
    chk("no pop while off", qa.size(), 2);
    wr(SFWD_TX_CTL_OFS, 8'h01);
    chk("tx enable", {tx_enable, lane_cnt}, 4'hC);
    wr(SFWD_TX_CTL_OFS, 8'h21);
    chk("lanes two", lane_cnt, 3'h2);
    wr(SFWD_STATUS_OFS, 8'hFF);
    rchk(SFWD_STATUS_OFS, 8'h00);
    wr(SFWD_PORT_FWD_OFS, 8'h00);
    rchk(SFWD_PORT_FWD_OFS, 8'h00);
    $display("Test registers finished");
    // Basic: whole frame per sensor, port 0 first, own channel ids
    start(SFWD_MODE_BASIC, 2'h0, 2'h1, 1'b0);
    frame(2);
    ex(SFWD_KIND_FS, 2'h0, 1, 0, 0, 1, 1, 0);
    ex(SFWD_KIND_FS, 2'h1, 1, 0, 0, 1, 1, 0);
    for (int l = 0; l < 2; l++) begin
      ex(SFWD_KIND_LINE, 2'h0, 3, 8'(8'h10 * (l + 1)), 16'h0003, 1, 1, 0);
      ex(SFWD_KIND_LINE, 2'h1, 3, 8'(8'h10 * (l + 1) + 8'h08), 16'h0003, 1, 1, 0);
    end
    ex(SFWD_KIND_FE, 2'h0, 1, 0, 0, 1, 1, 0);
    ex(SFWD_KIND_FE, 2'h1, 1, 0, 0, 1, 1, 0);
    check_seq("basic");
    // Interleave: one frame start and end, lines alternate
    start(SFWD_MODE_ILV, 2'h0, 2'h0, 1'b0);
    frame(2);
    ex(SFWD_KIND_FS, 2'h0, 1, 0, 0, 1, 1, 0);
    for (int l = 0; l < 2; l++) begin
      ex(SFWD_KIND_LINE, 2'h0, 3, 8'(8'h10 * (l + 1)), 16'h0003, 1, 1, 0);
      ex(SFWD_KIND_LINE, 2'h0, 3, 8'(8'h10 * (l + 1) + 8'h08), 16'h0003, 1, 1, 0);
    end
    ex(SFWD_KIND_FE, 2'h0, 1, 0, 0, 1, 1, 0);
    check_seq("interleave");
    // Concatenate with a stalling receiver: joined lines, port 0 channel id
    start(SFWD_MODE_CAT, 2'h1, 2'h3, 1'b1);
    frame(2);
    ex(SFWD_KIND_FS, 2'h1, 1, 0, 0, 1, 1, 0);
    for (int l = 0; l < 2; l++) begin
      ba = 8'(8'h10 * (l + 1));
      c = SFWD_CRC_SEED;
      for (int i = 0; i < 3; i++) c = crc_step(c, 8'(ba + i));
      for (int i = 0; i < 3; i++) c = crc_step(c, 8'(ba + 8'h08 + i));
      ex(SFWD_KIND_LINE, 2'h1, 3, ba, 16'h0006, 1, 0, 0);
      ex(SFWD_KIND_LINE, 2'h1, 3, 8'(ba + 8'h08), 16'h0006, 0, 1, c);
    end
    ex(SFWD_KIND_FE, 2'h1, 1, 0, 0, 1, 1, 0);
    check_seq("concatenate");
    // Port 0 off: port 1 alone keeps its channel id, lines unjoined, port 0 untouched
    start(SFWD_MODE_CAT, 2'h1, 2'h3, 1'b0);
    wr(SFWD_PORT_FWD_OFS, 8'h01);
    frame(1);
    ex(SFWD_KIND_FS, 2'h3, 1, 0, 0, 1, 1, 0);
    ex(SFWD_KIND_LINE, 2'h3, 3, 8'h18, 16'h0003, 1, 1, 0);
    ex(SFWD_KIND_FE, 2'h3, 1, 0, 0, 1, 1, 0);
    check_seq("single port");
    chk("port 0 held", qa.size(), 5);
    // Sync loss: port 1 misses a line, rest discarded, restart at next frame start
    start(SFWD_MODE_BASIC, 2'h0, 2'h1, 1'b0);
    pkt(0, SFWD_KIND_FS, 1, 8'h00);
    pkt(0, SFWD_KIND_LINE, 3, 8'h50);
    pkt(0, SFWD_KIND_FE, 1, 8'h00);
    pkt(1, SFWD_KIND_FS, 1, 8'h00);
    pkt(1, SFWD_KIND_FE, 1, 8'h00);
    for (int w = 0; w < 200 && sync_lost !== 1'b1; w++) @(negedge clk);
    chk("lost flag", {sync_lost, synced}, 2'b10);
    repeat (30) @(negedge clk);
    chk("discarded", qa.size() + qb.size(), 0);
    frame(1);
    ex(SFWD_KIND_FS, 2'h0, 1, 0, 0, 1, 1, 0);
    ex(SFWD_KIND_FS, 2'h1, 1, 0, 0, 1, 1, 0);
    ex(SFWD_KIND_FS, 2'h0, 1, 0, 0, 1, 1, 0);
    ex(SFWD_KIND_FS, 2'h1, 1, 0, 0, 1, 1, 0);
    ex(SFWD_KIND_LINE, 2'h0, 3, 8'h10, 16'h0003, 1, 1, 0);
    ex(SFWD_KIND_LINE, 2'h1, 3, 8'h18, 16'h0003, 1, 1, 0);
    ex(SFWD_KIND_FE, 2'h0, 1, 0, 0, 1, 1, 0);
    ex(SFWD_KIND_FE, 2'h1, 1, 0, 0, 1, 1, 0);
    check_seq("sync loss");
    rchk(SFWD_STATUS_OFS, 8'h03);
    rchk(SFWD_STATUS_OFS, 8'h01);
    chk("lost cleared", sync_lost, 1'b0);
    wrap_up();
  end
endmodule

// >>> verification/sfwd_rx_model.sv
`timescale 1ns/100ps
module sfwd_rx_model
  import sfwd_pkg::*;
(
  input  wire logic        sys_clk_i,
  input  wire logic        nrst_i,
  input  wire logic        slow_i,
  input  wire sfwd_tx_type tx_i,
  output logic             tx_ready_o
);
  sfwd_tx_type beats[$];
  logic        phase;

  // Ready every cycle, or every other one when slow, so the engine must hold beats
  always @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      beats.delete();
      phase      <= 1'b0;
      tx_ready_o <= 1'b0;
    end else begin
      // Every accepted beat is kept in arrival order; streams are not told apart here
      if (tx_i.valid && tx_ready_o) begin
        beats.push_back(tx_i);
      end
      phase      <= ~phase;
      tx_ready_o <= ~slow_i | phase;
    end
  end
endmodule

// >>> verilog/sfwd_crc_step.sv
`timescale 1ns/100ps
module sfwd_crc_step
  import sfwd_pkg::*;
(
  input  wire logic [15:0] crc_i,
  input  wire logic [7:0]  data_i,
  output logic      [15:0] crc_o
);

  // One byte through the footer checksum, lsb first
  always_comb begin
    logic [15:0] c;
    c = crc_i;
    for (int i = 0; i < 8; i++) begin
      if (c[0] ^ data_i[i]) begin
        c = {1'b0, c[15:1]} ^ SFWD_CRC_POLY;
      end else begin
        c = {1'b0, c[15:1]};
      end
    end
    crc_o = c;
  end

endmodule

// >>> verilog/sfwd_engine.sv
// How it works
// [RQ1] Basic mode: each sensor frame goes out whole, with own FS, lines, FE.
// [RQ2] On sync failure stop emitting and restart at the next frame start.
// [RQ3] While not synchronized every buffer packet is popped and thrown away; the code keeps frame starts and pops only used ports while enabled.
// [RQ4] Basic frame end order: A last line, B last line, A FE, B FE.
// [RQ5] Basic mode: each packet carries its own receive port's channel id.
// [RQ6] Receiver tells streams apart by frame order when channel ids match.
// [RQ7] Line interleave: one FS and FE per merged frame, port B's dropped.
// [RQ8] Line interleave: lines of each stream go out as separate packets.
// [RQ9] Line interleave: one common channel id, unchecked; receiver uses line order.
// [RQ10] Line concatenate: one FS and FE per frame, port B's dropped.
// [RQ11] Line concatenate: matching lines joined into one packet, A bytes first.
// [RQ12] Joined line gets new word count and checksum over the joined payload.
// [RQ13] Joined bytes follow each other with no padding between sensors.
// [RQ14] Line concatenate: all packets carry the lowest forwarded port's channel id.
// [RQ15] Receiver splits joined lines back by byte position.
// [RQ16] Mode register 0x21: 0x04 basic, 0x28 interleave, 0x3C concatenate.
// [RQ17] Writing 0x1 to 0x33 enables the transmitter with four lanes.
// [RQ18] Writing 0x00 to 0x20 enables forwarding from both ports.
// [RQ19] Sync packets and lines go out port 0 first, then port 1.
// [RQ20] Status shows synchronized; sync-lost flag clears when read.
// [RQ21] Sources must be line-aligned with identical frame geometry.
// [RQ22] Sync-lost flag sets in the cycle discarding starts.
`timescale 1ns/100ps
module sfwd_engine
  import sfwd_pkg::*;
(
  input  wire logic          sys_clk_i,
  input  wire logic          nrst_i,
  input  wire logic          reg_wr_i,
  input  wire logic          reg_rd_i,
  input  wire logic [7:0]    reg_addr_i,
  input  wire logic [7:0]    reg_wdata_i,
  output logic      [7:0]    reg_rdata_o,
  input  wire sfwd_head_type head_a_i,
  input  wire sfwd_head_type head_b_i,
  input  wire logic [1:0]    vc_a_i,
  input  wire logic [1:0]    vc_b_i,
  output logic               pop_a_o,
  output logic               pop_b_o,
  input  wire logic          tx_ready_i,
  output sfwd_tx_type        tx_o,
  output logic               synced_o,
  output logic               sync_lost_o,
  output logic               tx_enable_o,
  output logic      [2:0]    tx_lane_count_o
);

  sfwd_state_type s_reg;
  sfwd_state_type s_next;
  sfwd_head_type  hd;
  logic [15:0]    crc_in;
  logic [15:0]    crc_out;
  logic           use_a;
  logic           use_b;
  logic           mode_ok;
  logic           is_cat;
  logic           is_ilv;
  logic           en;
  logic           in_flight;
  logic           slot_free;
  logic           a_fs;
  logic           b_fs;
  logic [1:0]     first_kind;
  logic           act;

  // Head of the buffer being forwarded and checksum start point
  assign hd     = s_reg.cur ? head_b_i : head_a_i;
  assign crc_in = (hd.sop && !s_reg.join_second) ? SFWD_CRC_SEED : s_reg.crc;

  sfwd_crc_step u_crc (
    .crc_i  (crc_in),
    .data_i (hd.data),
    .crc_o  (crc_out)
  );

  // Decode of control and the handshake conditions
  always_comb begin
    use_a      = !s_reg.port_ctl[SFWD_PORT_A_DIS_BIT];          // [RQ18]
    use_b      = !s_reg.port_ctl[SFWD_PORT_B_DIS_BIT];          // [RQ18]
    is_cat     = s_reg.mode_ctl == SFWD_MODE_CAT;               // [RQ16]
    is_ilv     = s_reg.mode_ctl == SFWD_MODE_ILV;               // [RQ16]
    mode_ok    = is_cat || is_ilv || s_reg.mode_ctl == SFWD_MODE_BASIC;
    en         = s_reg.tx_en && mode_ok && (use_a || use_b);
    // A pop issued last cycle leaves a stale head for one cycle
    in_flight  = s_reg.pop_a || s_reg.pop_b;
    slot_free  = !s_reg.tx.valid || tx_ready_i;
    a_fs       = head_a_i.valid && head_a_i.sop && head_a_i.kind == SFWD_KIND_FS;
    b_fs       = head_b_i.valid && head_b_i.sop && head_b_i.kind == SFWD_KIND_FS;
    first_kind = use_a ? head_a_i.kind : head_b_i.kind;
    act        = s_reg.fsm == ST_SEND && en && hd.valid && !in_flight && (s_reg.drop || slot_free);
  end

  // Register port, forwarding engine and output beat
  always_comb begin
    s_next       = s_reg;
    s_next.pop_a = 1'b0;
    s_next.pop_b = 1'b0;
    s_next.rdata = 8'h00;
    if (tx_ready_i) begin
      s_next.tx.valid = 1'b0;
    end
    if (reg_wr_i) begin
      case (reg_addr_i)
        SFWD_PORT_FWD_OFS: s_next.port_ctl = reg_wdata_i;           // [RQ18]
        SFWD_MODE_OFS:     s_next.mode_ctl = reg_wdata_i;           // [RQ16]
        SFWD_TX_CTL_OFS: begin
          s_next.tx_ctl = reg_wdata_i;
          s_next.tx_en  = reg_wdata_i[SFWD_TX_EN_BIT];              // [RQ17]
          s_next.lanes  = SFWD_LANES_MAX - {1'b0, reg_wdata_i[SFWD_LANE_LSB +: 2]}; // [RQ17]
        end
        default: ;
      endcase
    end
    if (reg_rd_i) begin
      case (reg_addr_i)
        SFWD_PORT_FWD_OFS: s_next.rdata = s_reg.port_ctl;
        SFWD_MODE_OFS:     s_next.rdata = s_reg.mode_ctl;
        SFWD_TX_CTL_OFS:   s_next.rdata = s_reg.tx_ctl;
        SFWD_STATUS_OFS: begin
          s_next.rdata[SFWD_STAT_SYNC_BIT] = s_reg.synced;          // [RQ20]
          s_next.rdata[SFWD_STAT_LOST_BIT] = s_reg.lost;
          s_next.lost                      = 1'b0;                  // [RQ20]
        end
        default: ;
      endcase
    end
    case (s_reg.fsm)
      ST_HUNT: begin
        // Throw away everything up to a frame start on each used port
        if (en && !in_flight) begin
          if (use_a && head_a_i.valid && !a_fs) begin
            s_next.pop_a = 1'b1;                                    // [RQ3]
          end
          if (use_b && head_b_i.valid && !b_fs) begin
            s_next.pop_b = 1'b1;                                    // [RQ3]
          end
          if ((!use_a || a_fs) && (!use_b || b_fs)) begin
            s_next.fsm    = ST_PAIR;                                // [RQ2]
            s_next.synced = 1'b1;
          end
        end
      end
      ST_PAIR: begin
        if (en && !in_flight && (!use_a || head_a_i.valid) && (!use_b || head_b_i.valid)) begin
          if (use_a && use_b && (head_a_i.kind != head_b_i.kind || !head_a_i.sop || !head_b_i.sop)) begin
            // Heads out of step: drop sync, flag it in the same cycle
            s_next.fsm    = ST_HUNT;                                // [RQ2]
            s_next.synced = 1'b0;
            s_next.lost   = 1'b1;                                   // [RQ22]
          end else begin
            s_next.fsm         = ST_SEND;
            s_next.cur         = !use_a;                            // [RQ19]
            s_next.chain       = use_a && use_b;                    // [RQ1] [RQ4] [RQ8]
            s_next.drop        = 1'b0;
            s_next.chain_drop  = (is_ilv || is_cat) && first_kind != SFWD_KIND_LINE; // [RQ7] [RQ10]
            s_next.join_first  = is_cat && use_a && use_b && first_kind == SFWD_KIND_LINE; // [RQ11]
            s_next.join_second = 1'b0;
          end
        end
      end
      ST_SEND: begin
        if (act) begin
          if (s_reg.cur) begin
            s_next.pop_b = 1'b1;
          end else begin
            s_next.pop_a = 1'b1;
          end
          if (!s_reg.drop) begin
            s_next.tx.valid = 1'b1;
            s_next.tx.sop   = hd.sop && !s_reg.join_second;         // [RQ13]
            s_next.tx.eop   = hd.eop && !s_reg.join_first;          // [RQ11]
            s_next.tx.kind  = hd.kind;
            s_next.tx.dt    = hd.dt;
            s_next.tx.data  = hd.data;
            s_next.tx.crc   = crc_out;                              // [RQ12]
            s_next.crc      = crc_out;
            if (is_cat) begin
              s_next.tx.vc = use_a ? vc_a_i : vc_b_i;               // [RQ14]
            end else begin
              s_next.tx.vc = s_reg.cur ? vc_b_i : vc_a_i;           // [RQ5] [RQ9]
            end
            if (s_reg.join_first) begin
              s_next.tx.wc = 16'(head_a_i.wc + head_b_i.wc);        // [RQ12]
            end else if (s_reg.join_second) begin
              s_next.tx.wc = s_reg.tx.wc;
            end else begin
              s_next.tx.wc = hd.wc;
            end
          end
          if (hd.eop) begin
            if (s_reg.chain) begin
              // Port 1's packet follows port 0's
              s_next.cur         = 1'b1;                            // [RQ4] [RQ19]
              s_next.chain       = 1'b0;
              s_next.drop        = s_reg.chain_drop;                // [RQ7] [RQ10]
              s_next.join_second = s_reg.join_first;                // [RQ11]
              s_next.join_first  = 1'b0;
            end else begin
              s_next.fsm         = ST_PAIR;
              s_next.join_second = 1'b0;
            end
          end
        end
      end
      default: s_next.fsm = ST_HUNT;
    endcase
    // Off or unconfigured: hold buffers, forget sync
    if (!en) begin
      s_next.fsm    = ST_HUNT;
      s_next.synced = 1'b0;
    end
  end

  // State register
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      s_reg          <= '0;
      s_reg.fsm      <= ST_HUNT;
      s_reg.port_ctl <= SFWD_PORT_FWD_RST;
      s_reg.mode_ctl <= SFWD_MODE_RST;
      s_reg.tx_ctl   <= SFWD_TX_CTL_RST;
      s_reg.lanes    <= SFWD_LANES_MAX;
      s_reg.crc      <= SFWD_CRC_SEED;
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs straight from the state register
  assign reg_rdata_o     = s_reg.rdata;
  assign pop_a_o         = s_reg.pop_a;
  assign pop_b_o         = s_reg.pop_b;
  assign tx_o            = s_reg.tx;
  assign synced_o        = s_reg.synced;
  assign sync_lost_o     = s_reg.lost;
  assign tx_enable_o     = s_reg.tx_en;
  assign tx_lane_count_o = s_reg.lanes;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);

  AST_LOST_ON_MISMATCH: assert property ( // [RQ22]
    s_reg.fsm == ST_PAIR && en && !in_flight && use_a && use_b && head_a_i.valid && head_b_i.valid
    && head_a_i.kind != head_b_i.kind |=> s_reg.lost && s_reg.fsm == ST_HUNT && !s_reg.synced)
    else $error("sync loss not flagged at once");

  AST_HUNT_NO_EMIT: assert property ( // [RQ2]
    s_reg.fsm == ST_HUNT && slot_free |=> !s_reg.tx.valid)
    else $error("beat emitted while hunting");

  AST_HUNT_DISCARDS: assert property ( // [RQ3]
    s_reg.fsm == ST_HUNT && en && !in_flight && use_a && head_a_i.valid && !a_fs
    |=> s_reg.pop_a && (!s_reg.tx.valid || s_reg.tx == $past(s_reg.tx)))
    else $error("packet not discarded while hunting");

  AST_B_AFTER_A: assert property ( // [RQ4]
    act && !s_reg.cur && hd.eop && s_reg.chain |=> s_reg.fsm == ST_SEND && s_reg.cur ##1 !s_reg.pop_a)
    else $error("port 1 does not follow port 0");

  AST_CAT_WC: assert property ( // [RQ12]
    act && s_reg.join_first && hd.sop |=> s_reg.tx.wc == 16'($past(head_a_i.wc) + $past(head_b_i.wc)) && !s_reg.tx.eop)
    else $error("joined word count wrong");

  AST_CAT_VC: assert property ( // [RQ14]
    act && !s_reg.drop && is_cat && use_a |=> s_reg.tx.vc == $past(vc_a_i))
    else $error("concatenated packet has wrong channel id");

  AST_BASIC_VC: assert property ( // [RQ5]
    act && !s_reg.drop && !is_cat && s_reg.cur |=> s_reg.tx.vc == $past(vc_b_i) && s_reg.tx.valid)
    else $error("basic packet has wrong channel id");

  AST_DROP_NO_EMIT: assert property ( // [RQ7]
    act && s_reg.drop && slot_free |=> !s_reg.tx.valid && s_reg.pop_b)
    else $error("dropped sync packet was emitted");

  AST_LOST_CLEAR: assert property ( // [RQ20]
    reg_rd_i && reg_addr_i == SFWD_STATUS_OFS
    |=> s_reg.rdata[SFWD_STAT_LOST_BIT] == $past(s_reg.lost) && s_reg.rdata[SFWD_STAT_SYNC_BIT] == $past(s_reg.synced)
    && (!s_reg.lost || $past(s_reg.fsm) == ST_PAIR))
    else $error("sync-lost flag not cleared by read");

  AST_TX_ENABLE: assert property ( // [RQ17]
    reg_wr_i && reg_addr_i == SFWD_TX_CTL_OFS && reg_wdata_i == 8'h01 |=> tx_enable_o && tx_lane_count_o == 3'h4)
    else $error("transmitter not enabled with four lanes");

  AST_MODE_OFF: assert property ( // [RQ16]
    !mode_ok |=> s_reg.fsm == ST_HUNT && !s_reg.pop_a && !s_reg.pop_b)
    else $error("engine active with unknown mode");

endmodule

// >>> verilog/sfwd_pkg.sv
package sfwd_pkg;

  // Register offsets on the register port
  localparam logic [7:0] SFWD_PORT_FWD_OFS   = 8'h20;
  localparam logic [7:0] SFWD_MODE_OFS       = 8'h21;
  localparam logic [7:0] SFWD_STATUS_OFS     = 8'h22;
  localparam logic [7:0] SFWD_TX_CTL_OFS     = 8'h33;

  // Values after reset: both ports disabled, forwarding and transmitter off
  localparam logic [7:0] SFWD_PORT_FWD_RST   = 8'h03;
  localparam logic [7:0] SFWD_MODE_RST       = 8'h00;
  localparam logic [7:0] SFWD_TX_CTL_RST     = 8'h00;

  // Synchronized forwarding mode codes
  localparam logic [7:0] SFWD_MODE_BASIC     = 8'h04;
  localparam logic [7:0] SFWD_MODE_ILV       = 8'h28;
  localparam logic [7:0] SFWD_MODE_CAT       = 8'h3C;

  // Field positions
  localparam int         SFWD_PORT_A_DIS_BIT = 0;
  localparam int         SFWD_PORT_B_DIS_BIT = 1;
  localparam int         SFWD_TX_EN_BIT      = 0;
  localparam int         SFWD_LANE_LSB       = 4;
  localparam int         SFWD_STAT_SYNC_BIT  = 0;
  localparam int         SFWD_STAT_LOST_BIT  = 1;
  localparam logic [2:0] SFWD_LANES_MAX      = 3'h4;

  // Packet kinds as they sit at a buffer head
  localparam logic [1:0] SFWD_KIND_FS        = 2'h0;
  localparam logic [1:0] SFWD_KIND_FE        = 2'h1;
  localparam logic [1:0] SFWD_KIND_LINE      = 2'h2;

  // Packet footer checksum, reflected form
  localparam logic [15:0] SFWD_CRC_SEED      = 16'hFFFF;
  localparam logic [15:0] SFWD_CRC_POLY      = 16'h8408;

  typedef enum logic [2:0] {
    ST_HUNT = 3'b001,
    ST_PAIR = 3'b010,
    ST_SEND = 3'b100
  } sfwd_fsm_type;

  // One byte of a packet at the head of a video buffer
  typedef struct packed {
    logic        valid;
    logic        sop;
    logic        eop;
    logic [1:0]  kind;
    logic [5:0]  dt;
    logic [15:0] wc;
    logic [7:0]  data;
  } sfwd_head_type;

  // One byte beat toward the transmitter
  typedef struct packed {
    logic        valid;
    logic        sop;
    logic        eop;
    logic [1:0]  kind;
    logic [1:0]  vc;
    logic [5:0]  dt;
    logic [15:0] wc;
    logic [7:0]  data;
    logic [15:0] crc;
  } sfwd_tx_type;

  typedef struct packed {
    sfwd_fsm_type fsm;
    logic         cur;
    logic         drop;
    logic         join_first;
    logic         join_second;
    logic         chain;
    logic         chain_drop;
    logic         pop_a;
    logic         pop_b;
    sfwd_tx_type  tx;
    logic [15:0]  crc;
    logic         synced;
    logic         lost;
    logic [7:0]   port_ctl;
    logic [7:0]   mode_ctl;
    logic [7:0]   tx_ctl;
    logic         tx_en;
    logic [2:0]   lanes;
    logic [7:0]   rdata;
  } sfwd_state_type;

endpackage
